// file: rtl/vid_reference_sequencer.sv
// The AHB-Lite slave port and the address map were left to the implementer.
module vid_reference_sequencer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  voltage_code,
  input  wire logic        dac_range_select,
  input  wire logic        output_enable_input,
  input  wire logic        logic_supply_ok,
  input  wire logic        driver_supply,
  input  wire logic        undervoltage_cmp,
  input  wire logic        overvoltage_cmp,
  input  wire logic        threshold_resistor,
  output logic [5:0]       reference_code,
  output logic [11:0]      soft_start_ramp,
  output logic             switching_on,
  output logic             lowside_crowbar,
  output logic             fault_output,
  output logic             soft_start_done,
  output logic             undervoltage_trip,
  output logic             overvoltage_trip,
  output logic             ovp_fixed_select,
  output logic             code_sampling_clock
);

  // ---------------- register bus ----------------
  logic [15:0] half_ff;
  logic [11:0] uvcnt_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] rdata_ff;

  wire        addr_ph = hsel & hready & htrans[1];
  wire        rd_take = addr_ph & ~hwrite;
  wire        wr_take = addr_ph & hwrite;
  wire [7:0]  a_off   = haddr[7:0];

  // sequencer state
  vid_seq_pkg::seq_state_t state_ff;
  vid_seq_pkg::seq_state_t nxt_state;
  logic [5:0]  ref_ff;
  logic [5:0]  target_ff;
  logic [5:0]  cand_ff;
  logic        cand_valid_ff;
  logic        stepping_ff;
  logic        step_armed_ff;
  logic [5:0]  last_code_ff;
  logic [11:0] ss_cnt_ff;
  logic        uv_seen_ff;

  // status word read back by software
  wire [31:0] status_word = (32'(ref_ff) << vid_seq_pkg::ST_REF_LSB)
                          | (32'(target_ff) << vid_seq_pkg::ST_TGT_LSB)
                          | (32'(state_ff) << vid_seq_pkg::ST_STATE_LSB)
                          | (32'(stepping_ff) << vid_seq_pkg::ST_STEP_BIT)
                          | (32'(dac_range_select) << vid_seq_pkg::ST_FINE_BIT);

  // read data selected during the address phase, unmapped reads as zero
  wire [31:0] rd_sel =
    (a_off == vid_seq_pkg::ADDR_HALF)   ? {16'h0000, half_ff} :
    (a_off == vid_seq_pkg::ADDR_UVCNT)  ? {20'h00000, uvcnt_ff} :
    (a_off == vid_seq_pkg::ADDR_STATUS) ? status_word :
    (a_off == vid_seq_pkg::ADDR_RAMP)   ? {20'h00000, ss_cnt_ff} : 32'h00000000;

  wire wr_half  = wr_pend_ff & (wr_addr_ff == vid_seq_pkg::ADDR_HALF);
  wire wr_uvcnt = wr_pend_ff & (wr_addr_ff == vid_seq_pkg::ADDR_UVCNT);

  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h00000000;
    end
    else
    begin
      wr_pend_ff <= wr_take;
      wr_addr_ff <= wr_take ? a_off : wr_addr_ff;
      rdata_ff   <= rd_take ? rd_sel : 32'h00000000;
    end
  end

  // writable configuration
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      half_ff  <= vid_seq_pkg::HALF_RESET;
      uvcnt_ff <= vid_seq_pkg::UV_AT_RESET;
    end
    else
    begin
      half_ff  <= wr_half ? hwdata[15:0] : half_ff;
      uvcnt_ff <= wr_uvcnt ? hwdata[11:0] : uvcnt_ff;
    end
  end

  assign hrdata    = rdata_ff;
  assign hreadyout = 1'b1;  // zero wait state, always OKAY
  assign hresp     = 1'b0;

  // ---------------- sampling clock ----------------
  logic [17:0] phase_cnt_ff;
  logic        sclk_ff;

  // half period in hclk cycles: 1x for fine range, 3x for coarse; zero taken as one
  wire [15:0] half_eff   = (half_ff == 16'h0000) ? 16'h0001 : half_ff;
  wire [17:0] half_limit = dac_range_select ? {2'b00, half_eff}
                                            : 18'(half_eff * vid_seq_pkg::COARSE_MUL);
  wire        ph_tick    = (phase_cnt_ff >= half_limit - 18'h00001);
  wire        rise_ev    = ph_tick & ~sclk_ff;
  wire        fall_ev    = ph_tick & sclk_ff;

  // phase counter and sampling clock level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_cnt_ff <= 18'h00000;
      sclk_ff      <= 1'b0;
    end
    else
    begin
      phase_cnt_ff <= ph_tick ? 18'h00000 : phase_cnt_ff + 18'h00001;
      sclk_ff      <= ph_tick ? ~sclk_ff : sclk_ff;
    end
  end

  assign code_sampling_clock = sclk_ff;

  // ---------------- state decisions ----------------
  function automatic logic is_no_processor_state(input logic [5:0] code);
    is_no_processor_state = (code[5:1] == vid_seq_pkg::NO_PROCESSOR_STATE_CODE);
  endfunction

  wire supplies_ok  = logic_supply_ok & driver_supply;
  wire code_no_processor_state   = is_no_processor_state(voltage_code);
  wire code_moved   = (voltage_code != last_code_ff);
  wire ss_finished  = (ss_cnt_ff == vid_seq_pkg::SS_STEPS);
  wire in_soft      = (state_ff == vid_seq_pkg::ST_SOFT);
  wire in_run       = (state_ff == vid_seq_pkg::ST_RUN);

  // protections: masked during a transition, UV late in soft start
  wire uv_active = (in_run & ~stepping_ff)
                 | (in_soft & (ss_cnt_ff >= uvcnt_ff));
  wire ov_active = (in_run & ~stepping_ff) | in_soft;
  wire uv_hit    = uv_active & undervoltage_cmp & uv_seen_ff;
  wire ov_hit    = ov_active & overvoltage_cmp;

  // code confirmation and stepping
  wire confirm   = fall_ev & cand_valid_ff & (voltage_code == cand_ff)
                 & (cand_ff != ref_ff);
  wire do_step   = rise_ev & step_armed_ff;
  wire [5:0] ref_up   = ref_ff + 6'h01;
  wire [5:0] ref_down = ref_ff - 6'h01;
  wire [5:0] ref_next = (target_ff > ref_ff) ? ref_up : ref_down;
  wire       reached  = do_step & (ref_next == target_ff);

  // next state
  always_comb
  begin
    nxt_state = state_ff;
    if (!supplies_ok || !output_enable_input)
    begin
      nxt_state = vid_seq_pkg::ST_OFF;
    end
    else
    begin
      case (state_ff)
        vid_seq_pkg::ST_OFF:
          nxt_state = code_no_processor_state ? vid_seq_pkg::ST_NO_PROCESSOR_STATE : vid_seq_pkg::ST_SOFT;
        vid_seq_pkg::ST_NO_PROCESSOR_STATE:
          if (code_moved && !code_no_processor_state)
          begin
            nxt_state = vid_seq_pkg::ST_SOFT;
          end
        vid_seq_pkg::ST_SOFT:
          if (ov_hit)
          begin
            nxt_state = vid_seq_pkg::ST_OVF;
          end
          else if (uv_hit)
          begin
            nxt_state = vid_seq_pkg::ST_UVF;
          end
          else if (code_no_processor_state)
          begin
            nxt_state = vid_seq_pkg::ST_NO_PROCESSOR_STATE;
          end
          else if (ss_finished)
          begin
            nxt_state = vid_seq_pkg::ST_RUN;
          end
        vid_seq_pkg::ST_RUN:
          if (ov_hit)
          begin
            nxt_state = vid_seq_pkg::ST_OVF;
          end
          else if (uv_hit)
          begin
            nxt_state = vid_seq_pkg::ST_UVF;
          end
          else if (code_no_processor_state)
          begin
            nxt_state = vid_seq_pkg::ST_NO_PROCESSOR_STATE;
          end
        default:
          nxt_state = state_ff;                                  // faults latch
      endcase
    end
  end

  // state register and edge/filter history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff     <= vid_seq_pkg::ST_OFF;
      uv_seen_ff   <= 1'b0;
      last_code_ff <= 6'h00;
    end
    else
    begin
      state_ff     <= nxt_state;
      uv_seen_ff   <= uv_active & undervoltage_cmp;
      last_code_ff <= voltage_code;
    end
  end

  // soft start ramp counter, one count per sampling clock period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ss_cnt_ff <= 12'h000;
    end
    else if (nxt_state != vid_seq_pkg::ST_SOFT && nxt_state != vid_seq_pkg::ST_RUN)
    begin
      ss_cnt_ff <= 12'h000;
    end
    else if (in_soft && rise_ev && !ss_finished)
    begin
      ss_cnt_ff <= ss_cnt_ff + 12'h001;
    end
  end

  // transition tracking: sample, confirm, arm, step
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_ff        <= 6'h00;
      target_ff     <= 6'h00;
      cand_ff       <= 6'h00;
      cand_valid_ff <= 1'b0;
      stepping_ff   <= 1'b0;
      step_armed_ff <= 1'b0;
    end
    else if (!in_run)
    begin
      // soft start aims straight at the present code
      ref_ff        <= voltage_code;
      target_ff     <= voltage_code;
      cand_valid_ff <= 1'b0;
      stepping_ff   <= 1'b0;
      step_armed_ff <= 1'b0;
    end
    else if (stepping_ff)
    begin
      // new codes ignored until the reference lands
      cand_valid_ff <= 1'b0;
      step_armed_ff <= ~reached;
      stepping_ff   <= ~reached;
      ref_ff        <= do_step ? ref_next : ref_ff;
    end
    else if (confirm)
    begin
      target_ff     <= cand_ff;
      stepping_ff   <= 1'b1;
      step_armed_ff <= 1'b1;
      cand_valid_ff <= 1'b0;
    end
    else if (rise_ev)
    begin
      cand_ff       <= voltage_code;
      cand_valid_ff <= 1'b1;
    end
  end

  // output flops: status flags decided from the next state, reference, ramp and OVP select registered copies
  wire nx_switch = (nxt_state == vid_seq_pkg::ST_SOFT) | (nxt_state == vid_seq_pkg::ST_RUN);
  wire nx_ovf    = (nxt_state == vid_seq_pkg::ST_OVF);
  wire nx_uvf    = (nxt_state == vid_seq_pkg::ST_UVF);

  logic switching_ff;
  logic crowbar_ff;
  logic fault_ff;
  logic done_ff;
  logic uvt_ff;
  logic ovt_ff;
  logic fixed_ff;
  logic [5:0]  refout_ff;
  logic [11:0] ramp_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      switching_ff <= 1'b0;
      crowbar_ff   <= 1'b0;
      fault_ff     <= 1'b0;
      done_ff      <= 1'b0;
      uvt_ff       <= 1'b0;
      ovt_ff       <= 1'b0;
      fixed_ff     <= 1'b0;
      refout_ff    <= 6'h00;
      ramp_ff      <= 12'h000;
    end
    else
    begin
      switching_ff <= nx_switch & supplies_ok;
      crowbar_ff   <= nx_ovf;
      fault_ff     <= nx_ovf | nx_uvf;
      done_ff      <= (nxt_state == vid_seq_pkg::ST_RUN);
      uvt_ff       <= nx_uvf;
      ovt_ff       <= nx_ovf;
      fixed_ff     <= threshold_resistor;
      refout_ff    <= ref_ff;
      ramp_ff      <= ss_cnt_ff;
    end
  end

  assign switching_on      = switching_ff;
  assign lowside_crowbar   = crowbar_ff;
  assign fault_output      = fault_ff;
  assign soft_start_done   = done_ff;
  assign undervoltage_trip = uvt_ff;
  assign overvoltage_trip  = ovt_ff;
  assign ovp_fixed_select  = fixed_ff;
  assign reference_code    = refout_ff;
  assign soft_start_ramp   = ramp_ff;

endmodule

// file: rtl/vid_seq_pkg.sv
package vid_seq_pkg;

  // timing base
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned FSW_HZ     = 150_000;
  // half period of the fine-range sampling clock (three times the switching rate)
  localparam logic [15:0] HALF_RESET = 16'(CLK_HZ / (FSW_HZ * 6));
  localparam logic [1:0]  COARSE_MUL = 2'h3;
  // soft start length in sampling clock periods
  localparam logic [11:0] SS_STEPS   = 12'h800;
  // ramp count at which the reference is taken to pass 0.6 V
  localparam logic [11:0] UV_AT_RESET = 12'h400;
  localparam logic [4:0]  NO_PROCESSOR_STATE_CODE = 5'h1F;

  // register byte offsets
  localparam logic [7:0] ADDR_HALF   = 8'h00;
  localparam logic [7:0] ADDR_UVCNT  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RAMP   = 8'h0C;

  // status field positions
  localparam int unsigned ST_REF_LSB    = 0;
  localparam int unsigned ST_TGT_LSB    = 8;
  localparam int unsigned ST_STATE_LSB  = 16;
  localparam int unsigned ST_STEP_BIT   = 24;
  localparam int unsigned ST_FINE_BIT   = 25;

  typedef enum logic [5:0] {
    ST_OFF   = 6'h01,
    ST_NO_PROCESSOR_STATE = 6'h02,
    ST_SOFT  = 6'h04,
    ST_RUN   = 6'h08,
    ST_UVF   = 6'h10,
    ST_OVF   = 6'h20
  } seq_state_t;

endpackage

// file: testbench/code_source.sv
module code_source (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       code_sampling_clock,
  input wire logic [5:0] want,
  input wire logic [3:0] min_rises,
  output logic     [5:0] voltage_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       last_ff;
  logic [3:0] rises_ff;
  // change the code only after enough sampling clock rises
  always @(posedge hclk)
  begin
    last_ff <= code_sampling_clock;
    if (!hresetn)
    begin
      voltage_code <= want;
      rises_ff <= 4'h0;
    end
    else if (want != voltage_code && rises_ff >= min_rises)
    begin
      voltage_code <= want;
      rises_ff <= 4'h0;
    end
    else if (code_sampling_clock && !last_ff && rises_ff != 4'hF)
      rises_ff <= rises_ff + 4'h1;
  end
endmodule

// file: testbench/test_vid_reference_sequencer.sv
module test_vid_reference_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, dac_range_select = 1, output_enable_input = 0;
  logic        logic_supply_ok = 1, driver_supply = 1, threshold_resistor = 0;
  logic        undervoltage_cmp = 0, overvoltage_cmp = 0;
  logic [5:0]  want, voltage_code, reference_code, a, b;
  logic [3:0]  min_rises;
  logic [11:0] soft_start_ramp;
  logic        switching_on, lowside_crowbar, fault_output, soft_start_done;
  logic        undervoltage_trip, overvoltage_trip, ovp_fixed_select, code_sampling_clock;
  wire logic   hready = hreadyout;
  int          mismatches = 0, n_checks = 0, cyc = 0;
  vid_reference_sequencer vid_reference_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .voltage_code(voltage_code),
    .dac_range_select(dac_range_select), .output_enable_input(output_enable_input),
    .logic_supply_ok(logic_supply_ok), .driver_supply(driver_supply),
    .undervoltage_cmp(undervoltage_cmp), .overvoltage_cmp(overvoltage_cmp),
    .threshold_resistor(threshold_resistor), .reference_code(reference_code),
    .soft_start_ramp(soft_start_ramp), .switching_on(switching_on),
    .lowside_crowbar(lowside_crowbar), .fault_output(fault_output),
    .soft_start_done(soft_start_done), .undervoltage_trip(undervoltage_trip),
    .overvoltage_trip(overvoltage_trip), .ovp_fixed_select(ovp_fixed_select),
    .code_sampling_clock(code_sampling_clock)
  );
  code_source code_source_i (
    .hclk(hclk), .hresetn(hresetn), .code_sampling_clock(code_sampling_clock),
    .want(want), .min_rises(min_rises), .voltage_code(voltage_code)
  );
  always #5 hclk = ~hclk;
  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single AHB transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] ad, wd, output logic [31:0] rd);
    hsel <= 1;
    haddr <= ad;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0); // slave always answers okay
  endtask
  task automatic rd_chk(input logic [31:0] ad, exp);
    bus(0, ad, 0, r);
    check(r, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wait_done;
    for (int k = 0; k < 20000 && soft_start_done !== 1'b1; k++) @(posedge hclk);
  endtask
  // reference model: targets must be visited in order, one step per period
  task automatic go_to(input logic [5:0] ta, tb, input int per);
    int q[$];
    int n;
    int last;
    logic [5:0] pr;
    q = {ta, tb};
    n = 0;
    last = -1;
    pr = reference_code;
    want <= ta;
    while (q.size() > 0 && n < 3000)
    begin
      @(posedge hclk);
      n++;
      if (reference_code !== pr)
      begin
        if (last < 0)
        begin
          overvoltage_cmp <= 1;
          want <= tb;
        end
        else
          check(n - last, per);
        last = n;
        pr = reference_code;
        if (reference_code === 6'(q[0]))
        begin
          void'(q.pop_front());
          last = -1;
        end
      end
      else
        overvoltage_cmp <= 0;
    end
    check(q.size(), 0);
    check(fault_output, 0);
  endtask
  initial
  begin
    void'($urandom(32'hD4F2));
    want = 6'($urandom_range(40, 1));
    min_rises = 4'($urandom_range(6, 3));
    tick(4);
    hresetn <= 1;
    tick(1);
    rd_chk(32'(vid_seq_pkg::ADDR_HALF), 32'(vid_seq_pkg::HALF_RESET));
    rd_chk(32'(vid_seq_pkg::ADDR_UVCNT), 32'(vid_seq_pkg::UV_AT_RESET));
    rd_chk(32'h10, 0);
    bus(1, 32'(vid_seq_pkg::ADDR_HALF), 1, r);
    bus(1, 32'(vid_seq_pkg::ADDR_RAMP), 5, r);
    rd_chk(32'(vid_seq_pkg::ADDR_HALF), 1);
    rd_chk(32'(vid_seq_pkg::ADDR_RAMP), 0);
    // fine range with half period one: sampling clock toggles every cycle
    r[0] = code_sampling_clock;
    tick(1);
    check(code_sampling_clock, !r[0]);
    output_enable_input <= 1;
    tick(300);
    undervoltage_cmp <= 1;
    tick(3);
    undervoltage_cmp <= 0;
    tick(2);
    check(fault_output, 0);
    overvoltage_cmp <= 1;
    tick(1);
    overvoltage_cmp <= 0;
    tick(3);
    check({lowside_crowbar, fault_output, overvoltage_trip}, 3'h7);
    output_enable_input <= 0;
    tick(3);
    check({fault_output, soft_start_done, switching_on}, 0);
    output_enable_input <= 1;
    wait_done();
    check({soft_start_done, switching_on, soft_start_ramp}, {2'h3, 12'h800});
    check(reference_code, want);
    bus(0, 32'(vid_seq_pkg::ADDR_STATUS), 0, r);
    check(r[25:16], 10'h208);
    // fine range then coarse range
    for (int m = 1; m >= 0; m--)
    begin
      dac_range_select <= 1'(m);
      tick(4);
      a = reference_code + 6'hA;
      // at least three steps back, so the injected overvoltage lands mid-transition
      b = 6'($urandom_range(int'(a) - 3, 1));
      go_to(a, b, m ? 2 : 6);
    end
    undervoltage_cmp <= 1;
    tick(1);
    undervoltage_cmp <= 0;
    tick(3);
    check(fault_output, 0);
    undervoltage_cmp <= 1;
    tick(3);
    undervoltage_cmp <= 0;
    tick(2);
    check({fault_output, undervoltage_trip, switching_on}, 3'h6);
    output_enable_input <= 0;
    tick(2);
    output_enable_input <= 1;
    wait_done();
    want <= 6'h3F;
    tick(60);
    check({soft_start_done, switching_on}, 0);
    want <= 6'h15;
    wait_done();
    check({soft_start_done, reference_code}, {1'b1, 6'h15});
    {logic_supply_ok, driver_supply, threshold_resistor} <= 3'h3;
    tick(3);
    check(switching_on, 0);
    {logic_supply_ok, driver_supply} <= 2'h2;
    tick(3);
    check({switching_on, ovp_fixed_select}, 2'h1);
    logic_supply_ok <= 1;
    driver_supply <= 1;
    tick(3);
    tally_and_finish();
  end
endmodule

// file: testbench/vid_seq_chk.sv
module vid_seq_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [5:0]  voltage_code,
  input wire logic        output_enable_input,
  input wire logic        logic_supply_ok,
  input wire logic        driver_supply,
  input wire logic        threshold_resistor,
  input wire logic [5:0]  reference_code,
  input wire logic [11:0] soft_start_ramp,
  input wire logic        switching_on,
  input wire logic        lowside_crowbar,
  input wire logic        fault_output,
  input wire logic        soft_start_done,
  input wire logic        undervoltage_trip,
  input wire logic        overvoltage_trip,
  input wire logic        ovp_fixed_select
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // powered and enabled for two samples, so the output lag has settled
  sequence s_enabled;
    (output_enable_input && logic_supply_ok && driver_supply)[*2];
  endsequence
  sequence s_pin_held;
    $stable(threshold_resistor)[*3];
  endsequence
  property p_supply_off;
    !(logic_supply_ok && driver_supply) |-> ##[1:2] !(switching_on || lowside_crowbar);
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("gates active without supply");
  property p_enable_low;
    !output_enable_input |-> ##[1:2] !(fault_output || soft_start_done || switching_on);
  endproperty
  a_enable_low: assert property (p_enable_low) else $error("enable low not honoured");
  property p_no_processor_state;
    voltage_code[5:1] == 5'h1F |-> ##[1:2] !(soft_start_done || switching_on);
  endproperty
  a_no_processor_state: assert property (p_no_processor_state) else $error("no processor code not honoured");
  property p_step;
    soft_start_done && $past(soft_start_done) && reference_code != $past(reference_code)
      |-> 6'(reference_code - $past(reference_code)) inside {6'h01, 6'h3F};
  endproperty
  a_step: assert property (p_step) else $error("reference moved by more than one code");
  property p_done_ramp;
    $rose(soft_start_done) |-> soft_start_ramp == vid_seq_pkg::SS_STEPS;
  endproperty
  a_done_ramp: assert property (p_done_ramp) else $error("done before full ramp");
  property p_uv_latch;
    (s_enabled ##0 undervoltage_trip) |=> undervoltage_trip && fault_output;
  endproperty
  a_uv_latch: assert property (p_uv_latch) else $error("undervoltage fault not latched");
  property p_ov_crowbar;
    overvoltage_trip |-> lowside_crowbar && fault_output && !switching_on;
  endproperty
  a_ov_crowbar: assert property (p_ov_crowbar) else $error("overvoltage without crowbar");
  property p_ovp_sel;
    s_pin_held |-> ovp_fixed_select == threshold_resistor;
  endproperty
  a_ovp_sel: assert property (p_ovp_sel) else $error("threshold select wrong");
endmodule

bind vid_reference_sequencer vid_seq_chk vid_seq_chk_i (
  .hclk(hclk), .hresetn(hresetn), .voltage_code(voltage_code),
  .output_enable_input(output_enable_input), .logic_supply_ok(logic_supply_ok),
  .driver_supply(driver_supply), .threshold_resistor(threshold_resistor),
  .reference_code(reference_code), .soft_start_ramp(soft_start_ramp),
  .switching_on(switching_on), .lowside_crowbar(lowside_crowbar),
  .fault_output(fault_output), .soft_start_done(soft_start_done),
  .undervoltage_trip(undervoltage_trip), .overvoltage_trip(overvoltage_trip),
  .ovp_fixed_select(ovp_fixed_select)
);
